/* core/adcrs_pkg.sv */
// Purpose: Constants and types of the converter ready/sync/readout block
// Assumes: 100 MHz core clock
// Notes: Offsets are APB byte addresses
package adcrs_pkg;
    // ********************************
    // Timing
    // ********************************
    localparam int CLK_MHZ = 100;
    localparam int CONV_TIME_NS = 20000;
    localparam int CONV_CYC = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam logic [15:0] CONV_LAST = 16'(CONV_CYC - 1);
    localparam int RDYH_NS = 100;
    localparam int RDYH_CYC = (RDYH_NS * CLK_MHZ + 999) / 1000;
    localparam logic [15:0] RDYH_AT = 16'(CONV_CYC - 1 - RDYH_CYC);
    // ********************************
    // Register offsets
    // ********************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_IO = 8'h04;
    localparam logic [7:0] ADDR_CHAN = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_DATA = 8'h10;
    // ********************************
    // Reset values and write masks
    // ********************************
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] IO_RST = 32'h0000_0000;
    localparam logic [31:0] CHAN_RST = 32'h0000_0001;
    localparam logic [31:0] CTRL_WMASK = 32'h0000_07ff;
    localparam logic [31:0] IO_WMASK = 32'h0000_0ef7;
    localparam logic [31:0] CHAN_WMASK = 32'h0000_01ff;
    // ********************************
    // Field positions
    // ********************************
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DUTY_BIT = 4;
    localparam int CTRL_CONT_BIT = 5;
    localparam int CTRL_APPEND_BIT = 6;
    localparam int CTRL_CRC_BIT = 7;
    localparam int CTRL_FIFO_BIT = 8;
    localparam int CTRL_CLKSEL_BIT = 9;
    localparam int CTRL_REFHOLD_BIT = 10;
    localparam int IO_PINSEL_LSB = 0;
    localparam int IO_P0EN_BIT = 2;
    localparam int IO_GPO_LSB = 4;
    localparam int IO_GPOEN_LSB = 9;
    localparam int CHAN_EN_LSB = 0;
    localparam int CHAN_REP_LSB = 4;
    // ********************************
    // Codes and counts
    // ********************************
    localparam logic [3:0] MODE_CONT = 4'h0;
    localparam logic [3:0] MODE_SINGLE = 4'h1;
    localparam logic [3:0] MODE_DUTY = 4'h9;
    localparam logic [1:0] PIN_DOUT = 2'h0;
    localparam logic [1:0] PIN_CLK = 2'h1;
    localparam logic [1:0] PIN_P0 = 2'h2;
    localparam logic [7:0] CMD_READ_DATA = 8'h42;
    localparam logic [6:0] SWRST_LAST = 7'h3f;
    localparam logic [7:0] DUTY_MULT_4 = 8'h03;
    localparam logic [7:0] DUTY_MULT_16 = 8'h0f;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [5:0] LEN_DATA = 6'h18;
    localparam logic [5:0] LEN_BYTE = 6'h08;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_CONV, SEQ_STBY} adcrs_seq_t;
endpackage : adcrs_pkg

/* core/adcrs_top.sv */
// Purpose: Conversion sequencing, data-ready, continuous read and sync
// Assumes: One 100 MHz clock; serial pins and sync are asynchronous
// Notes: Conversion results are a channel tag and a sample count
//
// Behaviour
// - Duty mode converts every enabled channel, stands by, restarts lowest.
// - Mode code 1001 selects autonomous duty cycling.
// - Duty ratio 1/4 by default, 1/16 when ratio select is set.
// - Repeat count is ignored in duty mode.
// - Each completed conversion clears ready bit and drives data-ready low.
// - Data-ready returns high once the result is read.
// - Pin select routes data-ready to data-out, clock pin or pin zero.
// - Unread result: data-ready pulses high briefly before next completion.
// - Repeat reads allowed normally; continuous read gives each result once.
// - Interrupt use of a pin overrides its clock or output function.
// - Pin zero as data-ready keeps general outputs enabled in standby.
// - FIFO enabled: ready fixed on data-out, continuous read disabled.
// - Continuous read shifts data without command, ignoring early clocks.
// - Unfinished continuous read is reloaded at next conversion completion.
// - Continuous read accepts only data reads; host writes it last.
// - Command 0x42 while ready low exits; CRC includes assumed 0x42.
// - Sixty-four clocks with data-in high perform full software reset.
// - Channels output in turn, status byte appended when enabled.
// - Sync low holds converter reset and ready high; restart after rise.
// - Sync sampled on falling clock edge; release on following fall.
// - Mode 0001 converts sequence once, stands by, ignores writes meanwhile.
//
// The APB interface to the registers and the address map were chosen for this implementation.
module adcrs_top
    import adcrs_pkg::*;
(
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    // APB slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Serial interface
    input wire logic SCLK_IN,
    input wire logic CS_N_IN,
    input wire logic DIN_IN,
    output logic DOUT_OUT,
    output logic DOUT_OE_OUT,
    // Sync input
    input wire logic SYNC_N_IN,
    // Shared pins
    output logic CLK_PIN_OUT,
    output logic CLK_PIN_OE_OUT,
    output logic [3:0] GENERAL_OUTPUT_OUT,
    output logic [3:0] GENERAL_OUTPUT_OE_OUT,
    // Analog side controls
    output logic MODULATOR_RESET_OUT,
    output logic STANDBY_OUT,
    output logic REFERENCE_ON_OUT
);
    // ********************************
    // Functions
    // ********************************
    // Next enabled channel above cur; bit 2 set when wrapping to lowest
    function automatic logic [2:0] next_ch(input logic [3:0] en, input logic [1:0] cur);
        logic [1:0] lo;
        logic [1:0] hi;
        logic found;
        lo = 2'h0;
        hi = 2'h0;
        found = 1'b0;
        for (int i = 3; i >= 0; i--) begin
            if (en[i]) begin
                lo = 2'(i);
                if (i > int'(cur)) begin
                    hi = 2'(i);
                    found = 1'b1;
                end
            end
        end
        return found ? {1'b0, hi} : {1'b1, lo};
    endfunction : next_ch

    // CRC-8 over the first 32 bits, or all 40 when whole is set
    function automatic logic [7:0] crc8(input logic [39:0] msg, input logic whole);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 39; i >= 0; i--) begin
            if (whole || i >= 8) begin
                c = (c[7] ^ msg[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction : crc8

    function automatic logic is_mapped(input logic [7:0] a);
        return a == ADDR_CTRL || a == ADDR_IO || a == ADDR_CHAN ||
            a == ADDR_STATUS || a == ADDR_DATA;
    endfunction : is_mapped

    // ********************************
    // Declarations
    // ********************************
    logic [2:0] sclk_s_r;
    logic [2:0] cs_s_r;
    logic [1:0] din_s_r;
    logic sync_meta_r;
    logic sync_smp_r;
    logic sync_d_r;
    logic soft_rst_r;
    logic [31:0] ctrl_r;
    logic [31:0] io_r;
    logic [31:0] chan_r;
    logic [31:0] prdata_r;
    adcrs_seq_t seq_st_r;
    logic [1:0] ch_r;
    logic [1:0] res_ch_r;
    logic [4:0] rep_r;
    logic [15:0] cnt_r;
    logic [7:0] slots_r;
    logic [7:0] stby_r;
    logic start_pend_r;
    logic [21:0] smp_r;
    logic [23:0] data_r;
    logic rdy_n_r;
    logic [39:0] sh_r;
    logic [5:0] bits_r;
    logic shifting_r;
    logic [7:0] rx_r;
    logic [2:0] rx_cnt_r;
    logic [6:0] swr_cnt_r;
    logic clkout_r;
    logic rst_all;
    logic sclk_rise;
    logic cs_low;
    logic sync_hold;
    logic apb_acc;
    logic apb_wr;
    logic wr_lock;
    logic start;
    logic conv_end;
    logic slot_end;
    logic spi_done;
    logic read_done;
    logic cmd_hit;
    logic cont_clr;
    logic cont_eff;
    logic [3:0] mode;
    logic [3:0] ch_en;
    logic [4:0] rep_lim;
    logic [2:0] nxt;
    logic [2:0] lowest;
    logic [7:0] status_byte;
    logic [39:0] frame;
    logic [5:0] frame_len;
    logic int_clk;
    logic int_p0;
    logic standby;

    // ********************************
    // Input synchronisers
    // ********************************
    // Serial pins, two stages before use
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            sclk_s_r <= 3'h7;
            cs_s_r <= 3'h7;
            din_s_r <= 2'h0;
        end else begin
            sclk_s_r <= {sclk_s_r[1:0], SCLK_IN};
            cs_s_r <= {cs_s_r[1:0], CS_N_IN};
            din_s_r <= {din_s_r[0], DIN_IN};
        end
    end

    always_ff @(negedge MCLK_IN) begin
        if (RST_IN) begin
            sync_meta_r <= 1'b1;
            sync_smp_r <= 1'b1;
        end else begin
            sync_meta_r <= SYNC_N_IN;
            sync_smp_r <= sync_meta_r;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            sync_d_r <= 1'b1;
        end else begin
            sync_d_r <= sync_smp_r;
        end
    end

    // Edge and level decode
    assign sclk_rise = sclk_s_r[1] & ~sclk_s_r[2];
    assign cs_low = ~cs_s_r[1];
    assign sync_hold = ~sync_d_r;
    assign rst_all = RST_IN | soft_rst_r;

    // ********************************
    // Register file
    // ********************************
    assign mode = ctrl_r[CTRL_MODE_LSB +: 4];
    assign ch_en = chan_r[CHAN_EN_LSB +: 4];
    assign cont_eff = ctrl_r[CTRL_CONT_BIT] & ~ctrl_r[CTRL_FIFO_BIT];
    assign apb_acc = PSEL_IN & PENABLE_IN;
    assign wr_lock = cont_eff | (mode == MODE_SINGLE && seq_st_r == SEQ_CONV);
    assign apb_wr = apb_acc & PWRITE_IN & ~wr_lock;
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = apb_acc & (~is_mapped(PADDR_IN) | (PWRITE_IN &
        (wr_lock | PADDR_IN == ADDR_STATUS | PADDR_IN == ADDR_DATA)));
    assign PRDATA_OUT = prdata_r;
    assign status_byte = {rdy_n_r, 3'h0, standby, 1'b0, res_ch_r};

    // Writable registers
    always_ff @(posedge MCLK_IN) begin
        if (rst_all) begin
            ctrl_r <= CTRL_RST;
            io_r <= IO_RST;
            chan_r <= CHAN_RST;
        end else begin
            if (apb_wr && PADDR_IN == ADDR_CTRL) begin
                ctrl_r <= PWDATA_IN & CTRL_WMASK;
            end else if (cont_clr) begin
                ctrl_r[CTRL_CONT_BIT] <= 1'b0;
            end
            if (apb_wr && PADDR_IN == ADDR_IO) begin
                io_r <= PWDATA_IN & IO_WMASK;
            end
            if (apb_wr && PADDR_IN == ADDR_CHAN) begin
                chan_r <= PWDATA_IN & CHAN_WMASK;
            end
        end
    end

    // Read data captured in setup phase
    always_ff @(posedge MCLK_IN) begin
        if (rst_all) begin
            prdata_r <= 32'h0000_0000;
        end else if (PSEL_IN && !PENABLE_IN) begin
            unique case (PADDR_IN)
                ADDR_CTRL: prdata_r <= ctrl_r;
                ADDR_IO: prdata_r <= io_r;
                ADDR_CHAN: prdata_r <= chan_r;
                ADDR_STATUS: prdata_r <= {24'h00_0000, status_byte};
                ADDR_DATA: prdata_r <= {8'h00, data_r};
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // ********************************
    // Conversion sequencer
    // ********************************
    assign nxt = next_ch(ch_en, ch_r);
    assign lowest = next_ch(ch_en, 2'h3);
    assign rep_lim = (mode == MODE_DUTY) ? 5'h00 : chan_r[CHAN_REP_LSB +: 5];
    assign conv_end = seq_st_r == SEQ_CONV && cnt_r == CONV_LAST;
    assign slot_end = seq_st_r == SEQ_STBY && cnt_r == CONV_LAST;
    assign start = start_pend_r | (apb_wr && (PADDR_IN == ADDR_CTRL ||
        PADDR_IN == ADDR_CHAN));
    assign standby = seq_st_r != SEQ_CONV;

    // Sequence state, channel and timers
    always_ff @(posedge MCLK_IN) begin
        if (rst_all) begin
            seq_st_r <= SEQ_IDLE;
            ch_r <= 2'h0;
            rep_r <= 5'h00;
            cnt_r <= 16'h0000;
            slots_r <= 8'h00;
            stby_r <= 8'h00;
            start_pend_r <= 1'b1;
        end else if (sync_hold) begin
            // held in reset, restart after rise
            seq_st_r <= SEQ_IDLE;
            cnt_r <= 16'h0000;
            start_pend_r <= 1'b1;
        end else if (start) begin
            start_pend_r <= 1'b0;
            cnt_r <= 16'h0000;
            rep_r <= 5'h00;
            slots_r <= 8'h00;
            ch_r <= lowest[1:0];
            if (ch_en != 4'h0 && (mode == MODE_CONT || mode == MODE_SINGLE ||
                mode == MODE_DUTY)) begin
                seq_st_r <= SEQ_CONV;
            end else begin
                seq_st_r <= SEQ_IDLE;
            end
        end else begin
            unique case (seq_st_r)
                SEQ_IDLE: begin
                    cnt_r <= 16'h0000;
                end
                SEQ_CONV: begin
                    if (!conv_end) begin
                        cnt_r <= cnt_r + 16'h0001;
                    end else begin
                        cnt_r <= 16'h0000;
                        slots_r <= slots_r + 8'h01;
                        if (rep_r < rep_lim) begin
                            rep_r <= rep_r + 5'h01;
                        end else begin
                            rep_r <= 5'h00;
                            ch_r <= nxt[1:0];
                            if (nxt[2]) begin
                                slots_r <= 8'h00;
                                if (mode == MODE_SINGLE) begin
                                    seq_st_r <= SEQ_IDLE;
                                end else if (mode == MODE_DUTY) begin
                                    seq_st_r <= SEQ_STBY;
                                    stby_r <= 8'((slots_r + 8'h01) *
                                        (ctrl_r[CTRL_DUTY_BIT] ? DUTY_MULT_16 : DUTY_MULT_4));
                                end
                            end
                        end
                    end
                end
                SEQ_STBY: begin
                    if (!slot_end) begin
                        cnt_r <= cnt_r + 16'h0001;
                    end else begin
                        cnt_r <= 16'h0000;
                        if (stby_r <= 8'h01) begin
                            seq_st_r <= SEQ_CONV;
                            ch_r <= lowest[1:0];
                        end else begin
                            stby_r <= stby_r - 8'h01;
                        end
                    end
                end
            endcase
        end
    end

    // Result register and sample count
    always_ff @(posedge MCLK_IN) begin
        if (rst_all) begin
            smp_r <= 22'h00_0000;
            data_r <= 24'h00_0000;
            res_ch_r <= 2'h0;
        end else if (conv_end) begin
            smp_r <= smp_r + 22'h00_0001;
            data_r <= {ch_r, smp_r};
            res_ch_r <= ch_r;
        end
    end

    // ********************************
    // Data-ready
    // ********************************
    assign read_done = spi_done | (apb_acc && !PWRITE_IN && PADDR_IN == ADDR_DATA);

    always_ff @(posedge MCLK_IN) begin
        if (rst_all) begin
            rdy_n_r <= 1'b1;
        end else if (sync_hold) begin
            rdy_n_r <= 1'b1;
        end else if (conv_end) begin
            rdy_n_r <= 1'b0;
        end else if (seq_st_r == SEQ_CONV && cnt_r == RDYH_AT) begin
            rdy_n_r <= 1'b1;
        end else if (read_done) begin
            rdy_n_r <= 1'b1;
        end
    end

    // ********************************
    // Serial readout
    // ********************************
    // frame with status and CRC
    always_comb begin
        frame = {data_r, 16'h0000};
        frame_len = LEN_DATA;
        if (ctrl_r[CTRL_APPEND_BIT]) begin
            frame[15:8] = status_byte;
            frame_len = LEN_DATA + LEN_BYTE;
            if (ctrl_r[CTRL_CRC_BIT]) begin
                frame[7:0] = crc8({CMD_READ_DATA, data_r, status_byte}, 1'b1);
                frame_len = LEN_DATA + LEN_BYTE + LEN_BYTE;
            end
        end else if (ctrl_r[CTRL_CRC_BIT]) begin
            frame[15:8] = crc8({CMD_READ_DATA, data_r, 8'h00}, 1'b0);
            frame_len = LEN_DATA + LEN_BYTE;
        end
    end

    assign cmd_hit = sclk_rise && cs_low && rx_cnt_r == 3'h7 &&
        {rx_r[6:0], din_s_r[1]} == CMD_READ_DATA && (!cont_eff || !rdy_n_r);
    assign cont_clr = cmd_hit & cont_eff;
    assign spi_done = shifting_r && sclk_rise && cs_low && bits_r == 6'h01;

    // Output shift register
    always_ff @(posedge MCLK_IN) begin
        if (rst_all) begin
            sh_r <= 40'h00_0000_0000;
            bits_r <= 6'h00;
            shifting_r <= 1'b0;
        end else if ((cont_eff && conv_end) || cmd_hit) begin
            // load without command, reload on update
            sh_r <= frame;
            bits_r <= frame_len;
            shifting_r <= 1'b1;
        end else if (shifting_r && !cs_low && !cont_eff) begin
            shifting_r <= 1'b0;
        end else if (shifting_r && sclk_rise && cs_low) begin
            // done clears, one read per load
            sh_r <= {sh_r[38:0], 1'b0};
            bits_r <= bits_r - 6'h01;
            shifting_r <= bits_r != 6'h01;
        end
    end

    // Command receiver
    always_ff @(posedge MCLK_IN) begin
        if (rst_all || !cs_low || (cont_eff && conv_end)) begin
            rx_r <= 8'h00;
            rx_cnt_r <= 3'h0;
        end else if (sclk_rise && (!shifting_r || cont_eff)) begin
            rx_r <= {rx_r[6:0], din_s_r[1]};
            rx_cnt_r <= rx_cnt_r + 3'h1;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (rst_all || !cs_low) begin
            swr_cnt_r <= 7'h00;
        end else if (sclk_rise) begin
            swr_cnt_r <= din_s_r[1] ? swr_cnt_r + 7'h01 : 7'h00;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            soft_rst_r <= 1'b0;
        end else begin
            soft_rst_r <= sclk_rise && cs_low && din_s_r[1] && swr_cnt_r == SWRST_LAST;
        end
    end

    // ********************************
    // Pin routing
    // ********************************
    // interrupt pin decode
    assign int_clk = !ctrl_r[CTRL_FIFO_BIT] && io_r[IO_PINSEL_LSB +: 2] == PIN_CLK;
    assign int_p0 = !ctrl_r[CTRL_FIFO_BIT] && io_r[IO_PINSEL_LSB +: 2] == PIN_P0;

    // Registered pin drivers
    always_ff @(posedge MCLK_IN) begin
        if (rst_all) begin
            DOUT_OUT <= 1'b1;
            DOUT_OE_OUT <= 1'b0;
            CLK_PIN_OUT <= 1'b0;
            CLK_PIN_OE_OUT <= 1'b0;
            GENERAL_OUTPUT_OUT <= 4'h0;
            GENERAL_OUTPUT_OE_OUT <= 4'h0;
            clkout_r <= 1'b0;
        end else begin
            clkout_r <= ~clkout_r;
            DOUT_OE_OUT <= cs_low;
            if (shifting_r) begin
                DOUT_OUT <= sh_r[39];
            end else begin
                DOUT_OUT <= (int_clk || int_p0) ? 1'b1 : rdy_n_r;
            end
            CLK_PIN_OE_OUT <= int_clk | ctrl_r[CTRL_CLKSEL_BIT];
            CLK_PIN_OUT <= int_clk ? rdy_n_r : clkout_r;
            GENERAL_OUTPUT_OUT <= {io_r[IO_GPO_LSB + 1 +: 3],
                int_p0 ? rdy_n_r : io_r[IO_GPO_LSB]};
            GENERAL_OUTPUT_OE_OUT <= {io_r[IO_GPOEN_LSB +: 3] & {3{!standby || int_p0}},
                int_p0 || (io_r[IO_P0EN_BIT] && !standby)};
        end
    end

    // Analog side controls
    always_ff @(posedge MCLK_IN) begin
        if (rst_all) begin
            MODULATOR_RESET_OUT <= 1'b1;
            STANDBY_OUT <= 1'b1;
            REFERENCE_ON_OUT <= 1'b0;
        end else begin
            MODULATOR_RESET_OUT <= sync_hold | standby;
            STANDBY_OUT <= standby;
            REFERENCE_ON_OUT <= !standby || ctrl_r[CTRL_REFHOLD_BIT];
        end
    end
endmodule : adcrs_top

/* sim/adcrs_chk.sv */
// Purpose: Port assertions of the converter control block
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to the top module
module adcrs_chk (
    // Watched ports
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire logic CS_N_IN,
    input wire logic DOUT_OE_OUT,
    input wire logic SYNC_N_IN,
    input wire logic MODULATOR_RESET_OUT,
    input wire logic STANDBY_OUT,
    input wire logic REFERENCE_ON_OUT
);
    // Single clock domain
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);
    property p_rst; $fell(RST_IN) |-> STANDBY_OUT && !DOUT_OE_OUT && !REFERENCE_ON_OUT; endproperty
    a_rst: assert property (p_rst)
        else $error("outputs off reset level");
    property p_sbm; STANDBY_OUT |-> MODULATOR_RESET_OUT; endproperty
    a_sbm: assert property (p_sbm)
        else $error("modulator free in standby");
    property p_ref; !REFERENCE_ON_OUT |-> STANDBY_OUT; endproperty
    a_ref: assert property (p_ref)
        else $error("converting without reference");
    property p_err; PSLVERR_OUT |-> PSEL_IN && PENABLE_IN; endproperty
    a_err: assert property (p_err)
        else $error("error outside access");
    property p_rdy; PSEL_IN && PENABLE_IN |-> PREADY_OUT; endproperty
    a_rdy: assert property (p_rdy)
        else $error("access not answered");
    property p_shold; !SYNC_N_IN [*5] |-> MODULATOR_RESET_OUT; endproperty
    a_shold: assert property (p_shold)
        else $error("modulator free while sync low");
    property p_srel; !SYNC_N_IN [*5] ##1 SYNC_N_IN |-> MODULATOR_RESET_OUT; endproperty
    a_srel: assert property (p_srel)
        else $error("modulator freed before falling edge");
    property p_csoe; CS_N_IN [*4] |-> !DOUT_OE_OUT; endproperty
    a_csoe: assert property (p_csoe)
        else $error("data-out driven while deselected");
    // Main scenarios
    c_sync: cover property ($rose(SYNC_N_IN));
    c_stby: cover property ($fell(STANDBY_OUT));
    c_err: cover property (PSLVERR_OUT);
endmodule : adcrs_chk
bind adcrs_top adcrs_chk u_chk (.MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
    .CS_N_IN(CS_N_IN), .DOUT_OE_OUT(DOUT_OE_OUT), .SYNC_N_IN(SYNC_N_IN),
    .MODULATOR_RESET_OUT(MODULATOR_RESET_OUT), .STANDBY_OUT(STANDBY_OUT),
    .REFERENCE_ON_OUT(REFERENCE_ON_OUT));

/* sim/adcrs_host.sv */
// Purpose: Serial host and sync driver facing the block
// Assumes: Core clock paces an 80 ns serial clock
// Notes: Serial clock idles high, data-in idles low
module adcrs_host (
    // Core clock, serial pins and sync
    input wire logic clk,
    input wire logic dout,
    output logic sclk,
    output logic cs_n,
    output logic din,
    output logic sync_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
        sync_n = 1'b1;
    end
    task xfer(input logic [7:0] cmd, input int nc, input int nz, input logic fill,
        output logic [23:0] rx);
        rx = 24'h0;
        cs_n <= 1'b0;
        for (int i = 0; i < nc + nz; i++) begin
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
            din <= (i < nc) ? cmd[3'(7 - i)] : fill;
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            rx = {rx[22:0], dout};
        end
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        din <= 1'b0;
    endtask : xfer
    // sync moves on a rising edge
    task sync_pulse(input int n);
        sync_n <= 1'b0;
        repeat (n) @(posedge clk);
        sync_n <= 1'b1;
    endtask : sync_pulse
endmodule : adcrs_host

/* sim/adcrs_top_tb.sv */
// Purpose: Self-checking bench of the converter control block
// Assumes: Ready routed to the clock pin
// Notes: Registers over APB, serial via host model
module adcrs_top_tb import adcrs_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic er;} adcrs_row_t;
    logic clk, er, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] pa = 8'h0;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic prdy, perr, dout, doe, ckp, ckoe, mr, sb, ron, sclk, cs_n, din, sync_n;
    logic [3:0] general_output, gpoe;
    logic [23:0] rx;
    int n_fail = 0;
    int samples_checked = 0, cnt;
    adcrs_row_t rows[8] = '{'{1'b0, ADDR_CTRL, 32'h0, CTRL_RST, 1'b0},
        '{1'b0, ADDR_IO, 32'h0, IO_RST, 1'b0}, '{1'b0, ADDR_CHAN, 32'h0, CHAN_RST, 1'b0},
        '{1'b1, ADDR_DATA, 32'h1, 32'h0, 1'b1}, '{1'b0, 8'h14, 32'h0, 32'h0, 1'b1},
        '{1'b1, ADDR_IO, 32'h1, 32'h0, 1'b0}, '{1'b1, ADDR_CTRL, 32'h200, 32'h0, 1'b0},
        '{1'b0, ADDR_IO, 32'h0, 32'h1, 1'b0}};
    // Core clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    adcrs_top u_dut (.MCLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(prdy),
        .PSLVERR_OUT(perr), .SCLK_IN(sclk), .CS_N_IN(cs_n), .DIN_IN(din), .DOUT_OUT(dout),
        .DOUT_OE_OUT(doe), .SYNC_N_IN(sync_n), .CLK_PIN_OUT(ckp), .CLK_PIN_OE_OUT(ckoe),
        .GENERAL_OUTPUT_OUT(general_output), .GENERAL_OUTPUT_OE_OUT(gpoe), .MODULATOR_RESET_OUT(mr),
        .STANDBY_OUT(sb), .REFERENCE_ON_OUT(ron));
    adcrs_host u_host (.clk(clk), .dout(dout), .sclk(sclk), .cs_n(cs_n), .din(din),
        .sync_n(sync_n));
    // Compare and count
    task chk(input logic [31:0] s, input logic [31:0] e, input string nm);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    // One APB transfer, held until ready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb
    // Cycles until ready pin or standby reaches a level
    task wt(input logic sel, input logic v);
        cnt = 0;
        while (((sel ? sb : ckp) !== v) && cnt < 40000) begin
            @(posedge clk);
            cnt++;
        end
    endtask : wt
    task give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    // Hang guard
    initial begin
        #900us;
        n_fail++;
        give_verdict();
    end
    // Test sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(rd, rows[i].e, "rdata");
            chk({31'h0, er}, {31'h0, rows[i].er}, "slverr");
        end
        $display("register rows done");
        wt(1'b0, 1'b0);
        chk({31'h0, cnt > 1000 && cnt < 40000}, 32'h1, "ready not clock");
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({31'h0, rd[7]}, 32'h0, "ready bit");
        u_host.xfer(CMD_READ_DATA, 8, 24, 1'b0, rx);
        apb(1'b0, ADDR_DATA, 32'h0);
        chk(rd, {8'h0, rx}, "serial data");
        chk({31'h0, ckp}, 32'h1, "ready after read");
        apb(1'b0, ADDR_DATA, 32'h0);
        chk(rd, {8'h0, rx}, "repeat read");
        wt(1'b0, 1'b0);
        wt(1'b0, 1'b1);
        wt(1'b0, 1'b0);
        chk({31'h0, cnt >= RDYH_CYC - 1 && cnt <= RDYH_CYC + 2}, 32'h1, "ready pulse");
        u_host.sync_pulse(20);
        chk({31'h0, ckp}, 32'h1, "ready in sync");
        wt(1'b0, 1'b0);
        chk({31'h0, cnt >= CONV_CYC - 2 && cnt <= CONV_CYC + 8}, 32'h1, "sync restart");
        $display("ready and sync done");
        apb(1'b1, ADDR_CHAN, 32'h31);
        apb(1'b1, ADDR_CTRL, 32'h400 | {28'h0, MODE_DUTY});
        wt(1'b1, 1'b1);
        chk({22'h0, ron, ckoe, general_output, gpoe}, 32'h300, "pins in standby");
        wt(1'b1, 1'b0);
        chk({31'h0, cnt >= 3 * CONV_CYC - 4 && cnt <= 3 * CONV_CYC + 4}, 32'h1, "quarter");
        apb(1'b1, ADDR_CTRL, 32'h419);
        wt(1'b1, 1'b1);
        wt(1'b1, 1'b0);
        chk({31'h0, cnt >= 15 * CONV_CYC - 4 && cnt <= 15 * CONV_CYC + 4}, 32'h1, "sixteenth");
        u_host.xfer(8'h0, 0, 64, 1'b1, rx);
        repeat (8) @(posedge clk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, CTRL_RST, "soft reset");
        $display("duty and soft reset done");
        give_verdict();
    end
endmodule : adcrs_top_tb
